// *** shared/ipc_pkg.sv ***
package ipc_pkg;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int NP = 8;
    localparam int NAUX = 16;
    localparam int SELW = 4;
    localparam int NU = 2;
    localparam int NCL = 4;

    // config latch indices; the byte address is four times the index
    localparam int CL0_IDX = 'h00;
    localparam int CL1_IDX = 'h01;
    localparam int CL2_IDX = 'h02;
    localparam int CL3_IDX = 'h03;

    localparam logic [AW-1:0] A_DR = 8'h10;
    localparam logic [AW-1:0] A_DM0 = 8'h14;
    localparam logic [AW-1:0] A_DM1 = 8'h18;
    localparam logic [AW-1:0] A_DM2 = 8'h1C;
    localparam logic [AW-1:0] A_SLW = 8'h20;
    localparam logic [AW-1:0] A_BIE = 8'h24;
    localparam logic [AW-1:0] A_AUX = 8'h28;
    localparam logic [AW-1:0] A_PS = 8'h2C;
    localparam logic [AW-1:0] A_UDE = 8'h30;
    localparam logic [AW-1:0] A_UPU = 8'h34;
    localparam logic [AW-1:0] A_UDR = 8'h38;
    localparam logic [AW-1:0] A_STAT = 8'h3C;
    localparam logic [AW-1:0] A_PF0 = 8'h40;
    localparam int PF_HI = 7;
    localparam int PF_LO = 5;

    // pin form fields
    localparam int PF_DR = 0;
    localparam int PF_PS = 1;
    localparam int PF_DM = 2;
    localparam int PF_SLW = 5;
    localparam int PF_BIE = 6;

    // config latch fields
    localparam int RDM_P1 = 2;
    localparam int RDM_P15 = 0;
    localparam int RPS_BIT = 7;
    localparam int DBG_BIT = 6;
    localparam int ECC_BIT = 2;
    localparam int DBG_SEL_LSB = 0;
    localparam int PHS_LSB = 4;
    localparam int RST_PIN = 2;
    localparam int USB_LSB = 6;

    localparam logic [7:0] CL0_RST = 8'h00;
    localparam logic [7:0] CL1_RST = 8'h00;
    localparam logic [7:0] CL2_RST = 8'h40;
    localparam logic [7:0] CL3_RST = 8'h05;

    localparam logic [2:0] SZ_WORD = 3'h2;
    localparam logic [1:0] RDM_PU = 2'h2;

    typedef enum logic [2:0] {
        DM_HIZ_AN = 3'b000,
        DM_HIZ_DG = 3'b001,
        DM_RES_PU = 3'b010,
        DM_RES_PD = 3'b011,
        DM_OD_LO = 3'b100,
        DM_OD_HI = 3'b101,
        DM_STRONG = 3'b110,
        DM_RES_UD = 3'b111
    } ipc_dm_t;

    typedef enum logic [1:0] {
        DBG_SEL_JTAG5 = 2'b00,
        DBG_SEL_JTAG4 = 2'b01,
        DBG_SEL_SWD = 2'b10,
        DBG_SEL_OFF = 2'b11
    } ipc_dbg_sel_t;
endpackage : ipc_pkg

// *** hdl/ipc_port_ctrl.sv ***
module ipc_port_ctrl (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic hsel,
    input wire logic [ipc_pkg::AW-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [ipc_pkg::DW-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [ipc_pkg::DW-1:0] hrdata,
    input wire logic [ipc_pkg::NP-1:0] pin_i,
    output logic [ipc_pkg::NP-1:0] pin_o,
    output logic [ipc_pkg::NP-1:0] pin_oe,
    output logic [ipc_pkg::NP-1:0] pin_pu,
    output logic [ipc_pkg::NP-1:0] pin_pd,
    output logic [ipc_pkg::NP-1:0] pin_ie,
    output logic [ipc_pkg::NP-1:0] pin_slow,
    input wire logic [ipc_pkg::NAUX-1:0] aux_oe,
    input wire logic special_io_regulated,
    input wire logic usb_mode,
    input wire logic [ipc_pkg::NU-1:0] usb_i,
    output logic [ipc_pkg::NU-1:0] usb_o,
    output logic [ipc_pkg::NU-1:0] usb_oe,
    output logic [ipc_pkg::NU-1:0] usb_pu,
    output logic ext_rst_n,
    output logic dbg_access_en,
    output logic dbg_jtag5,
    output logic dbg_jtag4,
    output logic dbg_swd,
    output logic ecc_en,
    output logic [3:0] clk_phase_dly
);
    import ipc_pkg::*;

    logic [7:0] cl_ff [NCL];
    logic [7:0] app_ff [NCL];
    logic dp_wr_ff;
    logic rd_wait_ff;
    logic [AW-1:0] dp_addr_ff;
    logic [DW-1:0] hrdata_ff;
    logic [NP-1:0] dr_ff;
    logic [NP-1:0] dm0_ff;
    logic [NP-1:0] dm1_ff;
    logic [NP-1:0] dm2_ff;
    logic [NP-1:0] slw_ff;
    logic [NP-1:0] bie_ff;
    logic [NP*SELW-1:0] auxsel_ff;
    logic [NU-1:0] ude_ff;
    logic [NU-1:0] upu_ff;
    logic [NU-1:0] udr_ff;
    logic [NP-1:0] nxt_dr;
    logic [NP-1:0] nxt_dm0;
    logic [NP-1:0] nxt_dm1;
    logic [NP-1:0] nxt_dm2;
    logic [NP-1:0] nxt_slw;
    logic [NP-1:0] nxt_bie;
    logic [NP-1:0] pin_ps;
    logic [7:0] pf_rd [NP];

    // bus decode
    wire ap_take = hsel && htrans[1] && hready;
    wire ap_wr = ap_take && hwrite && (hsize == SZ_WORD);
    wire ap_rd = ap_take && !hwrite;
    wire wr_dr = dp_wr_ff && (dp_addr_ff == A_DR);
    wire wr_dm0 = dp_wr_ff && (dp_addr_ff == A_DM0);
    wire wr_dm1 = dp_wr_ff && (dp_addr_ff == A_DM1);
    wire wr_dm2 = dp_wr_ff && (dp_addr_ff == A_DM2);
    wire wr_slw = dp_wr_ff && (dp_addr_ff == A_SLW);
    wire wr_bie = dp_wr_ff && (dp_addr_ff == A_BIE);
    wire wr_aux = dp_wr_ff && (dp_addr_ff == A_AUX);
    wire wr_ude = dp_wr_ff && (dp_addr_ff == A_UDE);
    wire wr_upu = dp_wr_ff && (dp_addr_ff == A_UPU);
    wire wr_udr = dp_wr_ff && (dp_addr_ff == A_UDR);
    wire wr_pf = dp_wr_ff && (dp_addr_ff[PF_HI:PF_LO] == A_PF0[PF_HI:PF_LO]);
    wire [2:0] pf_idx = dp_addr_ff[4:2];
    wire [7:0] hw_lo = hwdata[7:0];
    wire [NU-1:0] hw_usb = hwdata[USB_LSB+:NU];

    // latch fields; raw ones steer the reset load, applied ones the outputs
    wire [1:0] rdm_p1 = cl_ff[CL0_IDX][RDM_P1+:2];
    wire [1:0] rdm_p15 = cl_ff[CL2_IDX][RDM_P15+:2];
    wire rps_app = app_ff[CL2_IDX][RPS_BIT];
    wire [1:0] dbg_sel_app = app_ff[CL3_IDX][DBG_SEL_LSB+:2];

    assign hreadyout = !rd_wait_ff;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dp_wr_ff <= 1'b0;
            rd_wait_ff <= 1'b0;
            dp_addr_ff <= '0;
        end else begin
            if (hready) begin
                dp_wr_ff <= ap_wr;
                rd_wait_ff <= ap_rd;
                dp_addr_ff <= {haddr[AW-1:2], 2'b00};
            end else begin
                rd_wait_ff <= 1'b0;
            end
        end
    end

    // read mux, sampled in the wait cycle so a write just before is seen
    wire [7:0] rd_cl = cl_ff[dp_addr_ff[3:2]];
    wire cl_hit = dp_addr_ff[AW-1:4] == 4'h0;
    wire pf_hit = dp_addr_ff[PF_HI:PF_LO] == A_PF0[PF_HI:PF_LO];
    wire [7:0] rd_stat = {3'h0, usb_mode, rps_app, app_ff[CL2_IDX][DBG_BIT], dbg_sel_app};
    wire [DW-1:0] rd_val =
        cl_hit ? {24'h0, rd_cl} :
        (dp_addr_ff == A_DR) ? {24'h0, dr_ff} :
        (dp_addr_ff == A_DM0) ? {24'h0, dm0_ff} :
        (dp_addr_ff == A_DM1) ? {24'h0, dm1_ff} :
        (dp_addr_ff == A_DM2) ? {24'h0, dm2_ff} :
        (dp_addr_ff == A_SLW) ? {24'h0, slw_ff} :
        (dp_addr_ff == A_BIE) ? {24'h0, bie_ff} :
        (dp_addr_ff == A_AUX) ? auxsel_ff :
        (dp_addr_ff == A_PS) ? {24'h0, pin_ps} :
        (dp_addr_ff == A_UDE) ? {24'h0, ude_ff, 6'h00} :
        (dp_addr_ff == A_UPU) ? {24'h0, upu_ff, 6'h00} :
        (dp_addr_ff == A_UDR) ? {24'h0, udr_ff, 6'h00} :
        (dp_addr_ff == A_STAT) ? {24'h0, rd_stat} :
        pf_hit ? {24'h0, pf_rd[pf_idx]} :
        32'h0;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hrdata_ff <= '0;
        end else if (rd_wait_ff) begin
            hrdata_ff <= rd_val;
        end
    end

    // config latches survive rst_n; only power-on loads the defaults
    genvar k;
    generate
        for (k = 0; k < NCL; k++) begin : g_cl
            localparam logic [AW-1:0] A_CL = AW'(4 * (CL0_IDX + k));
            localparam logic [7:0] CL_DEF = (k == CL0_IDX) ? CL0_RST :
                (k == CL1_IDX) ? CL1_RST : (k == CL2_IDX) ? CL2_RST : CL3_RST;
            wire wr_cl = dp_wr_ff && (dp_addr_ff == A_CL);
            always_ff @(posedge ref_clk) begin
                if (!por_n) begin
                    cl_ff[k] <= CL_DEF;
                end else if (wr_cl) begin
                    cl_ff[k] <= hw_lo;
                end
            end
            // latched contents take hold only while reset is asserted
            always_ff @(posedge ref_clk) begin
                if (!por_n) begin
                    app_ff[k] <= CL_DEF;
                end else if (!rst_n) begin
                    app_ff[k] <= cl_ff[k];
                end
            end
        end
    endgenerate

    assign ext_rst_n = rps_app ? pin_i[RST_PIN] : 1'b1;
    assign dbg_access_en = app_ff[CL2_IDX][DBG_BIT];
    assign dbg_jtag5 = dbg_access_en && (dbg_sel_app == DBG_SEL_JTAG5);
    assign dbg_jtag4 = dbg_access_en && (dbg_sel_app == DBG_SEL_JTAG4);
    assign dbg_swd = dbg_access_en && (dbg_sel_app == DBG_SEL_SWD);
    assign ecc_en = app_ff[CL3_IDX][ECC_BIT];
    assign clk_phase_dly = app_ff[CL3_IDX][PHS_LSB+:4];

    // port registers; reset loads every pin with the latched mode
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dr_ff <= {NP{rdm_p1 == RDM_PU}};
            dm0_ff <= {NP{rdm_p1[0]}};
            dm1_ff <= {NP{rdm_p1[1]}};
            dm2_ff <= '0;
            slw_ff <= '0;
            bie_ff <= '0;
            auxsel_ff <= '0;
        end else begin
            dr_ff <= nxt_dr;
            dm0_ff <= nxt_dm0;
            dm1_ff <= nxt_dm1;
            dm2_ff <= nxt_dm2;
            slw_ff <= nxt_slw;
            bie_ff <= nxt_bie;
            if (wr_aux) begin
                auxsel_ff <= hwdata;
            end
        end
    end

    // usb pin bits change only through their own registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ude_ff <= '0;
            upu_ff <= {NU{rdm_p15 == RDM_PU}};
            udr_ff <= {NU{rdm_p15 == RDM_PU}};
        end else begin
            if (wr_ude) begin
                ude_ff <= hw_usb;
            end
            if (wr_upu) begin
                upu_ff <= hw_usb;
            end
            if (wr_udr) begin
                udr_ff <= hw_usb;
            end
        end
    end

    genvar u;
    generate
        for (u = 0; u < NU; u++) begin : g_usb
            assign usb_o[u] = udr_ff[u];
            assign usb_oe[u] = !usb_mode && (!udr_ff[u] || ude_ff[u]);
            assign usb_pu[u] = !usb_mode && udr_ff[u] && !ude_ff[u] && upu_ff[u];
        end
    endgenerate

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    property p_usb_low;
        (!usb_mode && !udr_ff[0]) |-> usb_oe[0] && !usb_o[0] && !usb_pu[0];
    endproperty
    a_usb_low: assert property (p_usb_low) else $error("usb pin low not strong");

    property p_usb_mode;
        usb_mode |-> (usb_oe == 2'h0) && (usb_pu == 2'h0);
    endproperty
    a_usb_mode: assert property (p_usb_mode) else $error("usb mode drives pin");

    property p_usb_keep;
        (dp_wr_ff && !wr_ude && !wr_upu) |=> $stable(ude_ff) && $stable(upu_ff);
    endproperty
    a_usb_keep: assert property (p_usb_keep) else $error("usb bits changed");

    property p_wr_dr;
        wr_dr |=> dr_ff == $past(hw_lo);
    endproperty
    a_wr_dr: assert property (p_wr_dr) else $error("data write not applied");

    property p_app_hold;
        ($past(rst_n) && $past(por_n)) |-> $stable(app_ff[CL2_IDX]) && $stable(app_ff[CL3_IDX]);
    endproperty
    a_app_hold: assert property (p_app_hold) else $error("config moved");

    property p_rst_pin;
        rps_app |-> !pin_oe[RST_PIN] && pin_pu[RST_PIN] && (ext_rst_n == pin_i[RST_PIN]);
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("reset pin wrong");

    property p_dbg_off;
        (!dbg_access_en || dbg_sel_app == DBG_SEL_OFF) |-> !dbg_jtag5 && !dbg_jtag4 && !dbg_swd;
    endproperty
    a_dbg_off: assert property (p_dbg_off) else $error("debug port open");

    property p_rd_wait;
        ap_rd |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");

    // per-pin drive logic
    genvar i;
    generate
        for (i = 0; i < NP; i++) begin : g_pin
            wire pf_me = wr_pf && (pf_idx == 3'(i));
            wire aux_on = aux_oe[auxsel_ff[SELW*i+:SELW]];
            wire [2:0] dm_i = {dm2_ff[i], dm1_ff[i], dm0_ff[i]};
            wire is_rst = (i == RST_PIN) && rps_app;
            ipc_dm_t eff;
            logic o_v;
            logic oe_v;
            logic pu_v;
            logic pd_v;
            logic ie_v;

            // port form and pin form both land here
            assign nxt_dr[i] = wr_dr ? hwdata[i] : pf_me ? hwdata[PF_DR] : dr_ff[i];
            assign nxt_dm0[i] = wr_dm0 ? hwdata[i] : pf_me ? hwdata[PF_DM] : dm0_ff[i];
            assign nxt_dm1[i] = wr_dm1 ? hwdata[i] : pf_me ? hwdata[PF_DM+1] : dm1_ff[i];
            assign nxt_dm2[i] = wr_dm2 ? hwdata[i] : pf_me ? hwdata[PF_DM+2] : dm2_ff[i];
            assign nxt_slw[i] = wr_slw ? hwdata[i] : pf_me ? hwdata[PF_SLW] : slw_ff[i];
            assign nxt_bie[i] = wr_bie ? hwdata[i] : pf_me ? hwdata[PF_BIE] : bie_ff[i];
            assign pf_rd[i] = {1'b0, bie_ff[i], slw_ff[i], dm_i, pin_ps[i], dr_ff[i]};

            assign eff = (bie_ff[i] && !aux_on) ? DM_HIZ_DG : ipc_dm_t'(dm_i);

            always_comb begin
                o_v = dr_ff[i];
                oe_v = 1'b0;
                pu_v = 1'b0;
                pd_v = 1'b0;
                ie_v = 1'b1;
                unique case (eff)
                    DM_HIZ_AN: begin
                        ie_v = 1'b0;
                    end
                    DM_HIZ_DG: begin
                        ie_v = 1'b1;
                    end
                    DM_RES_PU: begin
                        pu_v = dr_ff[i];
                        oe_v = !dr_ff[i];
                    end
                    DM_RES_PD: begin
                        pd_v = !dr_ff[i];
                        oe_v = dr_ff[i];
                    end
                    DM_OD_LO: begin
                        oe_v = !dr_ff[i];
                    end
                    DM_OD_HI: begin
                        oe_v = dr_ff[i];
                    end
                    DM_STRONG: begin
                        oe_v = 1'b1;
                    end
                    DM_RES_UD: begin
                        pu_v = dr_ff[i];
                        pd_v = !dr_ff[i];
                    end
                endcase
            end

            assign pin_o[i] = o_v && !is_rst;
            assign pin_oe[i] = oe_v && !is_rst;
            assign pin_pu[i] = is_rst || (pu_v && !special_io_regulated);
            assign pin_pd[i] = pd_v && !special_io_regulated && !is_rst;
            assign pin_ie[i] = ie_v || is_rst;
            assign pin_ps[i] = pin_i[i] && pin_ie[i];
            assign pin_slow[i] = slw_ff[i] && !is_rst &&
                (eff inside {DM_OD_LO, DM_OD_HI, DM_STRONG});

            property p_analog;
                (eff == DM_HIZ_AN && !is_rst) |-> !pin_ie[i] && !pin_oe[i] && !pin_ps[i];
            endproperty
            a_analog: assert property (p_analog) else $error("analog pin active");

            property p_slew;
                (eff inside {DM_RES_PU, DM_RES_PD, DM_RES_UD}) |-> !pin_slow[i];
            endproperty
            a_slew: assert property (p_slew) else $error("slew on resistive");

            property p_reset_mode;
                $rose(rst_n) |-> (dm_i == {1'b0, rdm_p1});
            endproperty
            a_reset_mode: assert property (p_reset_mode) else $error("reset mode");

            property p_pin_form;
                (pf_me && !wr_dr) |=> dr_ff[i] == $past(hwdata[PF_DR]);
            endproperty
            a_pin_form: assert property (p_pin_form) else $error("pin form lost");

            property p_bidir;
                (bie_ff[i] && !aux_on && !is_rst) |-> !pin_oe[i] && pin_ie[i];
            endproperty
            a_bidir: assert property (p_bidir) else $error("bidir not hiz");
        end
    endgenerate

    wire unused_ok = ^usb_i;
endmodule : ipc_port_ctrl

// *** tb/ipc_pin_partner.sv ***
module ipc_pin_partner (
    input wire logic ref_clk,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pu,
    input wire logic [7:0] pin_pd,
    input wire logic [7:0] ext_drv_en,
    input wire logic [7:0] ext_drv_val,
    output logic [7:0] pin_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] float_ff = 8'h00;

    // a floating pin with no pull shows a level that changes every cycle
    always_ff @(posedge ref_clk) begin
        float_ff <= ~float_ff;
    end

    // the device's strong drive wins, then the outside driver, then the pulls
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_i[i] = pin_oe[i] ? pin_o[i] : ext_drv_en[i] ? ext_drv_val[i] :
                pin_pu[i] ? 1'b1 : pin_pd[i] ? 1'b0 : float_ff[i];
        end
    end
endmodule : ipc_pin_partner

// *** tb/ipc_port_ctrl_bench.sv ***
module ipc_port_ctrl_bench;
    import ipc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, rst_n, por_n, hsel, hwrite, hreadyout, hresp, special_io_regulated, usb_mode;
    logic [AW-1:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, m;
    logic [DW-1:0] hwdata, hrdata, v;
    logic [NP-1:0] pin_i, pin_o, pin_oe, pin_pu, pin_pd, pin_ie, pin_slow, ext_en, ext_val;
    logic [NAUX-1:0] aux_oe;
    logic [NU-1:0] usb_o, usb_oe, usb_pu;
    logic ext_rst_n, dbg_access_en, dbg_jtag5, dbg_jtag4, dbg_swd, ecc_en;
    logic [3:0] clk_phase_dly;
    logic [39:0] pv;
    logic [7:0] lrst [4] = '{CL0_RST, CL1_RST, CL2_RST, CL3_RST};
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;

    assign pv = {pin_oe, pin_o & pin_oe, pin_pu, pin_pd, pin_ie};

    ipc_port_ctrl i_ipc_port_ctrl (
        .ref_clk(ref_clk), .rst_n(rst_n), .por_n(por_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu(pin_pu), .pin_pd(pin_pd),
        .pin_ie(pin_ie), .pin_slow(pin_slow), .aux_oe(aux_oe),
        .special_io_regulated(special_io_regulated), .usb_mode(usb_mode), .usb_i(2'h0),
        .usb_o(usb_o), .usb_oe(usb_oe), .usb_pu(usb_pu), .ext_rst_n(ext_rst_n),
        .dbg_access_en(dbg_access_en), .dbg_jtag5(dbg_jtag5), .dbg_jtag4(dbg_jtag4),
        .dbg_swd(dbg_swd), .ecc_en(ecc_en), .clk_phase_dly(clk_phase_dly)
    );

    ipc_pin_partner i_ipc_pin_partner (
        .ref_clk(ref_clk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu(pin_pu),
        .pin_pd(pin_pd), .ext_drv_en(ext_en), .ext_drv_val(ext_val), .pin_i(pin_i)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            end_sim();
        end
    end

    task end_sim;
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task chk(input logic [39:0] s, input logic [39:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %0t: got %h expected %h", $time, s, e);
        end
    endtask : chk

    task aph(input logic [AW-1:0] a, input logic w);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
    endtask : aph

    task dph;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
    endtask : dph

    task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        aph(a, 1'b1);
        hwdata <= d;
        dph();
    endtask : wr

    task rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        aph(a, 1'b0);
        dph();
        d = hrdata;
    endtask : rd

    task rstp;
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
    endtask : rstp

    // expected {oe, driven data, pull-up, pull-down, input enable} per mode
    function automatic logic [39:0] pexp(input logic [2:0] md, input logic [7:0] dv);
        logic [7:0] oe, pu, pd, ie;
        oe = 8'h00;
        pu = 8'h00;
        pd = 8'h00;
        ie = {8{md != 3'h0}};
        for (int i = 0; i < 8; i++) begin
            case (md)
                3'h2: begin pu[i] = dv[i]; oe[i] = ~dv[i]; end
                3'h3: begin pd[i] = ~dv[i]; oe[i] = dv[i]; end
                3'h4: oe[i] = ~dv[i];
                3'h5: oe[i] = dv[i];
                3'h6: oe[i] = 1'b1;
                3'h7: begin pu[i] = dv[i]; pd[i] = ~dv[i]; end
                default: ;
            endcase
        end
        return {oe, dv & oe, pu, pd, ie};
    endfunction : pexp

    initial begin
        rst_n = 1'b0;
        por_n = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = SZ_WORD;
        hwdata = 32'h0;
        aux_oe = 16'h0000;
        special_io_regulated = 1'b0;
        usb_mode = 1'b0;
        ext_en = 8'hFF;
        ext_val = 8'hA1;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk({dbg_access_en, dbg_jtag5, dbg_jtag4, dbg_swd, ecc_en, ext_rst_n, hresp},
            7'b1010110);
        chk(pv, 40'h0);
        for (int k = 0; k < 4; k++) begin
            rd(8'(k * 4), v);
            chk(v, {24'h0, lrst[k]});
        end
        rd(8'hFC, v);
        chk(v, 32'h0);
        wr(A_DR, 32'h55);
        wr(A_SLW, 32'hFF);
        for (int k = 0; k < 8; k++) begin
            m = 3'(k);
            wr(A_DM0, {24'h0, {8{m[0]}}});
            wr(A_DM1, {24'h0, {8{m[1]}}});
            wr(A_DM2, {24'h0, {8{m[2]}}});
            #1;
            chk(pv, pexp(m, 8'h55));
            if (m == 3'h6) chk(pin_slow, 8'hFF);
            if (m == 3'h2) chk(pin_slow, 8'h00);
            if (m < 3'h2) begin
                rd(A_PS, v);
                chk(v, m[0] ? 32'hA1 : 32'h0);
            end
        end
        wr(A_PF0 + 8'h0C, 32'h59);
        rd(A_DR, v);
        chk(v, 32'h5D);
        rd(A_DM0, v);
        chk(v, 32'hF7);
        rd(A_PF0 + 8'h0C, v);
        chk(v, 32'h59);
        wr(A_AUX, 32'hF00F);
        wr(A_BIE, 32'h09);
        for (int k = 0; k < 2; k++) begin
            @(posedge ref_clk);
            aux_oe <= (k == 1) ? 16'h8000 : 16'h7FFF;
            #1;
            chk({pin_oe[3], pin_pu[0], pin_ie[3]}, (k == 1) ? 3'b111 : 3'b001);
        end
        @(posedge ref_clk);
        special_io_regulated <= 1'b1;
        #1;
        chk({pin_pu, pin_pd}, 16'h0);
        @(posedge ref_clk);
        special_io_regulated <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            m = 3'(k);
            wr(A_UPU, {24'h0, {2{m[2]}}, 6'h0});
            wr(A_UDE, {24'h0, {2{m[1]}}, 6'h0});
            wr(A_UDR, {24'h0, {2{m[0]}}, 6'h0});
            #1;
            chk({usb_o, usb_oe, usb_pu}, {{2{m[0]}}, {2{~m[0] | m[1]}},
                {2{m[0] & m[2] & ~m[1]}}});
        end
        wr(A_DM0, 32'h0);
        rd(A_UDE, v);
        chk(v, 32'hC0);
        @(posedge ref_clk);
        usb_mode <= 1'b1;
        #1;
        chk({usb_oe, usb_pu}, 4'h0);
        for (int k = 0; k < 4; k++) begin
            m = 3'(k);
            wr(8'(CL2_IDX * 4), 32'hC0);
            wr(8'(CL3_IDX * 4), {24'h0, 4'(k), 1'b0, m[0], m[1:0]});
            if (k == 0) chk({dbg_jtag5, dbg_jtag4}, 2'b01);
            rstp();
            chk({dbg_jtag5, dbg_jtag4, dbg_swd, ecc_en, dbg_access_en, clk_phase_dly},
                {k == 0, k == 1, k == 2, m[0], 1'b1, 4'(k)});
            chk(ext_rst_n, 1'b0);
        end
        wr(8'(CL0_IDX * 4), 32'h08);
        wr(8'(CL2_IDX * 4), 32'h82);
        wr(8'(CL3_IDX * 4), 32'h02);
        rstp();
        chk(pv, pexp(3'h2, 8'hFF));
        chk({dbg_access_en, dbg_swd}, 2'b00);
        rd(A_UPU, v);
        chk(v, 32'hC0);
        rd(A_STAT, v);
        chk(v, 32'h1A);
        chk(ext_rst_n, 1'b0);
        @(posedge ref_clk);
        ext_en <= 8'h00;
        #1;
        chk(ext_rst_n, 1'b1);
        end_sim();
    end
endmodule : ipc_port_ctrl_bench
